// File: inc/log_pages_pkg.sv
// Constants, register map and types for the wear and scan log page framer.
package log_pages_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WEAR_EST_OFS = 8'h04;
  localparam logic [7:0] SCAN_STATE_OFS = 8'h08;
  localparam logic [7:0] SCAN_COUNT_OFS = 8'h0c;
  localparam logic [7:0] SCAN_PROG_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam int CTRL_SAVE_DIS_BIT = 0;
  localparam int STATUS_BUSY_BIT = 8;

  // ==========================================================================
  // Page layout
  localparam logic [5:0] WEAR_PAGE_CODE = 6'h11;
  localparam logic [5:0] SCAN_PAGE_CODE = 6'h15;
  localparam logic [15:0] WEAR_PARAM_CODE = 16'h0001;
  localparam logic [15:0] SCAN_PARAM_CODE = 16'h0000;
  localparam logic [7:0] WEAR_PARAM_LEN = 8'h04;
  localparam logic [7:0] SCAN_PARAM_LEN = 8'h0c;
  localparam logic [7:0] PARAM_CTRL = 8'h03;
  localparam logic [4:0] WEAR_PAGE_BYTES = 5'h0c;
  localparam logic [4:0] SCAN_PAGE_BYTES = 5'h14;
  localparam logic [15:0] WEAR_PAGE_LEN = 16'h0008;
  localparam logic [15:0] SCAN_ENTRY_COUNT = 16'h0000;
  localparam logic [15:0] SCAN_PAGE_LEN =
    16'h0013 + 16'h0018 * SCAN_ENTRY_COUNT - 16'h0003;

  // ==========================================================================
  // Values
  localparam logic [7:0] WEAR_RESET = 8'h00;
  localparam logic [15:0] WEAR_SAT_LIMIT = 16'h00fe;
  localparam logic [7:0] WEAR_SAT_VALUE = 8'hff;
  localparam logic [7:0] SCAN_IDLE = 8'h00;
  localparam logic [7:0] SCAN_MEDIUM = 8'h01;
  localparam logic [7:0] SCAN_PRESCAN = 8'h02;
  localparam logic [7:0] SCAN_HALT_FMT = 8'h05;
  localparam logic [7:0] SCAN_HALT_VENDOR = 8'h06;
  localparam logic [7:0] SCAN_HALT_TEMP = 8'h07;
  localparam logic [7:0] SCAN_SUSPENDED = 8'h08;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } frame_state_t;

  typedef enum logic {
    PAGE_WEAR = 1'b0,
    PAGE_SCAN = 1'b1
  } page_sel_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } log_byte_t;

  typedef struct packed {
    logic [31:0] minutes;
    logic [7:0] status;
    logic [15:0] count;
    logic [15:0] progress;
  } scan_snap_t;

endpackage : log_pages_pkg

// File: rtl/log_pages.sv
// Wear and background scan log page framer with APB control registers.
// Functional notes
// - wear header: save-disable, page 11h, length
// - wear page always carries one parameter
// - only parameter code 0001h is sent
// - endurance control byte format-linking is 11b
// - length 04h, three reserved, then percentage
// - endurance value starts at zero
// - estimates above 254 report as 255
// - endurance refreshed at least hourly
// - scan page code 15h, length 19+24N-3
// - status parameter bytes 4-19, entries 24 bytes
// - status parameter code, control, length, fields
// - power-on minutes sampled at request
// - status 00h idle, 01h scan, 02h prescan
// - halt codes 05h-07h, 08h suspended, others refused
// - progress over 65536, lifetime scan count
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
module log_pages (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [31:0] power_on_minutes_i,
  input wire logic hour_tick_i,
  input wire logic req_valid_i,
  input wire log_pages_pkg::page_sel_t req_page_i,
  output logic req_ready_o,
  output log_pages_pkg::log_byte_t log_byte_o,
  output logic log_valid_o,
  input wire logic log_ready_i
);
  import log_pages_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] saturate(input logic [15:0] est);
    saturate = (est > WEAR_SAT_LIMIT) ? WEAR_SAT_VALUE : est[7:0];
  endfunction : saturate

  function automatic logic legal_status(input logic [7:0] s);
    legal_status = (s <= SCAN_PRESCAN) ||
      ((s >= SCAN_HALT_FMT) && (s <= SCAN_SUSPENDED));
  endfunction : legal_status

  // Byte at offset idx of the selected page, sent in ascending offset order.
  function automatic logic [7:0] page_byte(input page_sel_t pg,
                                           input logic [4:0] idx,
                                           input logic ds,
                                           input logic [7:0] wear,
                                           input scan_snap_t sn);
    page_byte = 8'h00;
    if (pg == PAGE_WEAR) begin
      unique case (idx)
        5'h00: page_byte = {ds, 1'b0, WEAR_PAGE_CODE};
        5'h02: page_byte = WEAR_PAGE_LEN[15:8];
        5'h03: page_byte = WEAR_PAGE_LEN[7:0];
        5'h04: page_byte = WEAR_PARAM_CODE[15:8];
        5'h05: page_byte = WEAR_PARAM_CODE[7:0];
        5'h06: page_byte = PARAM_CTRL;
        5'h07: page_byte = WEAR_PARAM_LEN;
        5'h0b: page_byte = wear;
        default: page_byte = 8'h00;
      endcase
    end else begin
      unique case (idx)
        5'h00: page_byte = {2'b00, SCAN_PAGE_CODE};
        5'h02: page_byte = SCAN_PAGE_LEN[15:8];
        5'h03: page_byte = SCAN_PAGE_LEN[7:0];
        5'h04: page_byte = SCAN_PARAM_CODE[15:8];
        5'h05: page_byte = SCAN_PARAM_CODE[7:0];
        5'h06: page_byte = PARAM_CTRL;
        5'h07: page_byte = SCAN_PARAM_LEN;
        5'h08: page_byte = sn.minutes[31:24];
        5'h09: page_byte = sn.minutes[23:16];
        5'h0a: page_byte = sn.minutes[15:8];
        5'h0b: page_byte = sn.minutes[7:0];
        5'h0d: page_byte = sn.status;
        5'h0e: page_byte = sn.count[15:8];
        5'h0f: page_byte = sn.count[7:0];
        5'h10: page_byte = sn.progress[15:8];
        5'h11: page_byte = sn.progress[7:0];
        default: page_byte = 8'h00;
      endcase
    end
  endfunction : page_byte

  // ==========================================================================
  // State
  typedef struct packed {
    frame_state_t st;
    page_sel_t page;
    logic [4:0] idx;
    logic [4:0] bytes;
    log_byte_t out;
    logic valid;
    scan_snap_t snap;
    logic save_dis;
    logic [15:0] est;
    logic [7:0] wear;
    logic [7:0] scan_status;
    logic [15:0] scan_count;
    logic [15:0] scan_prog;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic accept;
  logic advance;
  logic [4:0] idx_next;
  scan_snap_t live_snap;

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign addr_ok = (paddr_i <= STATUS_OFS) && (paddr_i[1:0] == 2'b00);
  assign accept = (state_reg.st == ST_IDLE) && req_valid_i;
  assign advance = (state_reg.st == ST_SEND) && log_ready_i;
  assign idx_next = state_reg.idx + 5'h01;
  assign live_snap = '{minutes: power_on_minutes_i,
                       status: state_reg.scan_status,
                       count: state_reg.scan_count,
                       progress: state_reg.scan_prog};

  // ==========================================================================
  // APB slave: zero wait states, unmapped or refused writes flag pslverr.
  assign pready_o = 1'b1;

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr_i)
        CTRL_OFS: prdata_o = {31'h0, state_reg.save_dis};
        WEAR_EST_OFS: prdata_o = {16'h0000, state_reg.est};
        SCAN_STATE_OFS: prdata_o = {24'h000000, state_reg.scan_status};
        SCAN_COUNT_OFS: prdata_o = {16'h0000, state_reg.scan_count};
        SCAN_PROG_OFS: prdata_o = {16'h0000, state_reg.scan_prog};
        STATUS_OFS: prdata_o = {23'h0, state_reg.st == ST_SEND,
                                state_reg.wear};
        default: prdata_o = 32'h0000_0000;
      endcase
    end
  end

  assign pslverr_o = psel_i && penable_i && (!addr_ok ||
    (pwrite_i && paddr_i == SCAN_STATE_OFS && !legal_status(pwdata_i[7:0]))
    || (pwrite_i && paddr_i == STATUS_OFS));

  // ==========================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      unique case (paddr_i)
        CTRL_OFS: state_next.save_dis = pwdata_i[CTRL_SAVE_DIS_BIT];
        WEAR_EST_OFS: state_next.est = pwdata_i[15:0];
        SCAN_STATE_OFS: begin
          if (legal_status(pwdata_i[7:0])) begin
            state_next.scan_status = pwdata_i[7:0];
          end
        end
        SCAN_COUNT_OFS: state_next.scan_count = pwdata_i[15:0];
        SCAN_PROG_OFS: state_next.scan_prog = pwdata_i[15:0];
        default: state_next.est = state_reg.est;
      endcase
    end
    // The reported value lags the estimate by at most one hour tick.
    if (hour_tick_i) begin
      state_next.wear = saturate(state_reg.est);
    end
    unique case (state_reg.st)
      ST_IDLE: begin
        if (req_valid_i) begin
          state_next.st = ST_SEND;
          state_next.page = req_page_i;
          state_next.idx = 5'h00;
          state_next.bytes = (req_page_i == PAGE_WEAR) ?
            WEAR_PAGE_BYTES : SCAN_PAGE_BYTES;
          state_next.snap = live_snap;
          state_next.out.data = page_byte(req_page_i, 5'h00,
            state_reg.save_dis, state_reg.wear, live_snap);
          state_next.out.last = 1'b0;
          state_next.valid = 1'b1;
        end
      end
      ST_SEND: begin
        if (log_ready_i) begin
          if (state_reg.out.last) begin
            state_next.st = ST_IDLE;
            state_next.valid = 1'b0;
          end else begin
            state_next.idx = idx_next;
            state_next.out.data = page_byte(state_reg.page, idx_next,
              state_reg.save_dis, state_reg.wear, state_reg.snap);
            state_next.out.last = (idx_next == state_reg.bytes - 5'h01);
          end
        end
      end
      default: state_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
      state_reg.wear <= WEAR_RESET;
      state_reg.scan_status <= SCAN_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign req_ready_o = (state_reg.st == ST_IDLE);
  assign log_byte_o = state_reg.out;
  assign log_valid_o = state_reg.valid;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_take(page_sel_t pg);
    ce_i && accept && req_page_i == pg;
  endsequence

  sequence s_at(page_sel_t pg, logic [4:0] i);
    log_valid_o && state_reg.page == pg && state_reg.idx == i;
  endsequence

  a_wear_header: assert property (s_take(PAGE_WEAR) |=>
    log_byte_o.data == {state_reg.save_dis, 1'b0, WEAR_PAGE_CODE})
    else $error("wear page header byte wrong");
  a_wear_length: assert property (s_at(PAGE_WEAR, 5'h03) |->
    log_byte_o.data == 8'h08) else $error("wear page length wrong");
  a_wear_param_code: assert property (s_at(PAGE_WEAR, 5'h05) |->
    log_byte_o.data == 8'h01) else $error("wear parameter code wrong");
  a_wear_ctrl_byte: assert property (s_at(PAGE_WEAR, 5'h06) |->
    log_byte_o.data[1:0] == 2'b11) else $error("format-linking not 11b");
  a_wear_param_len: assert property (s_at(PAGE_WEAR, 5'h07) |->
    log_byte_o.data == 8'h04 && !log_byte_o.last)
    else $error("wear parameter length wrong");
  a_wear_saturate: assert property (ce_i && hour_tick_i &&
    state_reg.est > 16'h00fe |=> state_reg.wear == 8'hff)
    else $error("endurance not saturated at 255");
  a_wear_refresh: assert property (ce_i && hour_tick_i &&
    state_reg.est < 16'h00ff && !(wr_en && paddr_i == WEAR_EST_OFS)
    |=> state_reg.wear == $past(state_reg.est[7:0]))
    else $error("endurance not refreshed on hour tick");
  a_scan_page_code: assert property (s_take(PAGE_SCAN) |=>
    log_byte_o.data == 8'h15) else $error("scan page code wrong");
  a_scan_last: assert property (log_valid_o && log_byte_o.last |->
    state_reg.idx == ((state_reg.page == PAGE_SCAN) ? 5'd19 : 5'd11))
    else $error("page ends at wrong byte");
  a_scan_minutes: assert property (s_take(PAGE_SCAN) ##1
    (ce_i && log_ready_i) [*8] |=>
    log_byte_o.data == $past(power_on_minutes_i[31:24], 9))
    else $error("minutes not sampled at request");
  a_scan_status: assert property (s_at(PAGE_SCAN, 5'h0d) |->
    legal_status(log_byte_o.data)) else $error("illegal scan status");
  a_byte_hold: assert property (log_valid_o && !log_ready_i |=>
    $stable(log_byte_o) && log_valid_o)
    else $error("byte changed while stalled");
endmodule : log_pages

// File: sim/log_sink.sv
// Initiator side model that takes log page bytes off the stream.
`timescale 1ns/10ps
module log_sink (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic slow_i,
  input wire logic log_valid_i,
  input wire log_pages_pkg::log_byte_t log_byte_i,
  output logic log_ready_o
);
  import log_pages_pkg::*;
  logic [7:0] got_q[$];
  logic last_seen;
  logic tog;
  // A slow initiator refuses every other cycle, so each byte must stand.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tog <= 1'b0;
      last_seen <= 1'b0;
    end else begin
      tog <= ~tog;
      if (log_valid_i === 1'b1 && log_ready_o) begin
        got_q.push_back(log_byte_i.data);
        last_seen <= log_byte_i.last;
      end
    end
  end
  assign log_ready_o = !slow_i || tog;
endmodule : log_sink

// File: sim/media_wear_and_scan_log_pages_tb_top.sv
// Self-checking bench for the wear and scan log page framer.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  error_cnt++; $display("wrong value at %0t: %h vs %h", $time, a, b); \
  end end
module media_wear_and_scan_log_pages_tb_top;
  import log_pages_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, mins = 0;
  logic pready, pslverr, tick_p = 0, req_v = 0, req_rdy, lv, slow = 0;
  page_sel_t req_pg = PAGE_WEAR;
  log_byte_t lb;
  int error_cnt = 0, comparisons = 0;
  logic lr;

  // ==========================================================================
  // Design and initiator model
  log_pages log_pages_inst (.ref_clk_i(clk), .reset_n_i(rst_n),
    .ce_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .power_on_minutes_i(mins),
    .hour_tick_i(tick_p), .req_valid_i(req_v), .req_page_i(req_pg),
    .req_ready_o(req_rdy), .log_byte_o(lb), .log_valid_o(lv),
    .log_ready_i(lr));
  log_sink log_sink_inst (.ref_clk_i(clk), .reset_n_i(rst_n),
    .slow_i(slow), .log_valid_i(lv), .log_byte_i(lb), .log_ready_o(lr));

  initial begin
    forever #4 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic hung();
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    stop_test();
  endtask : hung

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic xe,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) hung();
    q = prdata;
    `CHK(pslverr, xe)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick();
    @(posedge clk);
    tick_p <= 1'b1;
    @(posedge clk);
    tick_p <= 1'b0;
  endtask : tick

  task automatic page(input page_sel_t pg, input int n,
                      input logic [7:0] e[20]);
    int k;
    logic ok;
    log_sink_inst.got_q.delete();
    @(posedge clk);
    req_v <= 1'b1;
    req_pg <= pg;
    // Ready is judged mid-cycle, so the edge that takes the request is known.
    for (k = 0; k < 50; k++) begin
      @(negedge clk);
      ok = (req_rdy === 1'b1);
      @(posedge clk);
      if (ok) break;
    end
    if (k == 50) hung();
    req_v <= 1'b0;
    mins <= ~mins;
    for (k = 0; k < 200 && log_sink_inst.got_q.size() < n; k++) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    `CHK(log_sink_inst.got_q.size(), n)
    `CHK(log_sink_inst.last_seen, 1'b1)
    for (k = 0; k < n && k < log_sink_inst.got_q.size(); k++) begin
      `CHK(log_sink_inst.got_q[k], e[k])
    end
  endtask : page

  // ==========================================================================
  // Scenarios
  task automatic t_wear();
    logic [31:0] q;
    logic [7:0] e[20];
    apb(1'b0, STATUS_OFS, 0, 1'b0, q);
    `CHK(q[7:0], 8'h00)
    apb(1'b1, WEAR_EST_OFS, 32'h37, 1'b0, q);
    apb(1'b1, CTRL_OFS, 32'h1, 1'b0, q);
    tick();
    e = '{0: 8'h91, 3: 8'h08, 5: 8'h01, 6: 8'h03, 7: 8'h04,
          11: 8'h37, default: 8'h00};
    page(PAGE_WEAR, 12, e);
    apb(1'b1, CTRL_OFS, 32'h0, 1'b0, q);
    slow <= 1'b1;
    e[0] = 8'h11;
    page(PAGE_WEAR, 12, e);
    slow <= 1'b0;
    $display("test wear done");
  endtask : t_wear

  task automatic t_sat();
    logic [31:0] q;
    logic [15:0] w[4] = '{16'h0064, 16'h00fe, 16'h00ff, 16'h1234};
    logic [7:0] x[4] = '{8'h64, 8'hfe, 8'hff, 8'hff};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, WEAR_EST_OFS, {16'h0, w[i]}, 1'b0, q);
      tick();
      apb(1'b0, STATUS_OFS, 0, 1'b0, q);
      `CHK(q[7:0], x[i])
    end
    $display("test saturation done");
  endtask : t_sat

  task automatic t_scan();
    logic [31:0] q, m;
    logic [7:0] e[20];
    logic [7:0] c[7] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08};
    for (int i = 0; i < 7; i++) begin
      m = 32'h01020304 + i;
      mins <= m;
      slow <= i[0];
      apb(1'b1, SCAN_STATE_OFS, {24'h0, c[i]}, 1'b0, q);
      apb(1'b1, SCAN_COUNT_OFS, 32'h1200 + i, 1'b0, q);
      apb(1'b1, SCAN_PROG_OFS, 32'hbe00 + i, 1'b0, q);
      e = '{0: 8'h15, 3: 8'h10, 6: 8'h03, 7: 8'h0c, 8: m[31:24],
            9: m[23:16], 10: m[15:8], 11: m[7:0], 13: c[i], 14: 8'h12,
            15: 8'(i), 16: 8'hbe, 17: 8'(i), default: 8'h00};
      page(PAGE_SCAN, 20, e);
    end
    slow <= 1'b0;
    $display("test scan done");
  endtask : t_scan

  task automatic t_refuse();
    logic [31:0] q;
    logic [7:0] b[4] = '{8'h03, 8'h04, 8'h09, 8'hff};
    apb(1'b1, SCAN_STATE_OFS, 32'h1, 1'b0, q);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, SCAN_STATE_OFS, {24'h0, b[i]}, 1'b1, q);
    end
    apb(1'b0, SCAN_STATE_OFS, 0, 1'b0, q);
    `CHK(q[7:0], 8'h01)
    apb(1'b0, 8'h40, 0, 1'b1, q);
    `CHK(q, 32'h0)
    apb(1'b1, STATUS_OFS, 32'h5, 1'b1, q);
    $display("test refusal done");
  endtask : t_refuse

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_wear();
    t_sat();
    t_scan();
    t_refuse();
    stop_test();
  end
endmodule : media_wear_and_scan_log_pages_tb_top
